// ==== hw/lmci_pkg.sv ====
// shared constants and carrier types for the command and indication block
package lmci_pkg;

    // register offsets (word index = byte address / 4)
    localparam logic [7:0] ADDR_CTRL     = 8'h00; // mode and polarity bits
    localparam logic [7:0] ADDR_CONFIRM  = 8'h04; // default frame type, count
    localparam logic [7:0] ADDR_POWER    = 8'h08; // power index, force
    localparam logic [7:0] ADDR_RATE     = 8'h0C; // default rate index
    localparam logic [7:0] ADDR_PORT     = 8'h10; // application port
    localparam logic [7:0] ADDR_CHAN     = 8'h14; // add channel command
    localparam logic [7:0] ADDR_SEND     = 8'h18; // send payload command
    localparam logic [7:0] ADDR_STATUS   = 8'h1C; // block state
    localparam logic [7:0] ADDR_CHMASK   = 8'h20; // enabled channel mask
    localparam logic [7:0] ADDR_LIMIT    = 8'h24; // unanswered limit
    localparam logic [7:0] ADDR_REMOTE   = 8'h28; // remote command counts

    // control register fields
    localparam int CTRL_COFREQ  = 0;  // co_frequency_setting
    localparam int CTRL_POL_LO  = 8;  // polarity bits 8..13, one per line

    // confirm / send fields
    localparam int CNF_TYPE     = 0;  // frame type bit
    localparam int CNF_CNT_LO   = 4;  // count nibble 7:4
    localparam int SND_OVR      = 8;  // send: override defaults

    // power fields
    localparam int PWR_FORCE    = 8;  // forced-power bit

    // channel command fields
    localparam int CH_IDX_LO    = 0;  // index 3:0
    localparam int CH_HASMIN    = 4;  // min rate given
    localparam int CH_HASMAX    = 5;  // max rate given
    localparam int CH_MIN_LO    = 8;  // min rate 10:8
    localparam int CH_MAX_LO    = 12; // max rate 14:12
    localparam int CH_FREQ_LO   = 16; // frequency code 31:16

    // sizes and limits
    localparam int NUM_CH       = 15;
    localparam int NUM_DEF_CH   = 3;
    localparam int NUM_IND      = 6;
    localparam logic [7:0] REMOTE_PORT = 8'hDD; // 221
    localparam logic [7:0] PORT_MAX    = 8'hDF; // 223
    localparam logic [2:0] RATE_MAX    = 3'h5;
    localparam logic [2:0] PWR_IDX_MAX = 3'h7;
    localparam logic [4:0] DBM_TOP     = 5'h14; // 20
    localparam logic [4:0] DBM_FORCE   = 5'h16; // 22
    localparam logic [2:0] DEF_MIN_DR  = 3'h0;
    localparam logic [2:0] DEF_MAX_DR  = 3'h5;
    localparam logic [3:0] SF_TOP      = 4'hC; // 12
    localparam logic [7:0] RESP_MAX    = 8'h40; // response length limit
    localparam logic [3:0] MISS_LIMIT_RST = 4'h4;
    localparam logic [3:0] CNT_RST     = 4'h1;
    localparam logic [7:0] PORT_RST    = 8'h01;

    // indication line order
    localparam int IND_BUSY = 0;
    localparam int IND_RX1  = 1;
    localparam int IND_RX2  = 2;
    localparam int IND_SLP  = 3;
    localparam int IND_TX   = 4;
    localparam int IND_RXA  = 5;

    // stored channel entry
    typedef struct packed {
        logic        valid;
        logic [15:0] freq;
        logic [2:0]  min_dr;
        logic [2:0]  max_dr;
    } lmci_chan_t;

    // radio-side events from the modem
    typedef struct packed {
        logic tx_done;   // uplink finished on air
        logic ack;       // acknowledgement seen
        logic rx1_open;  // level
        logic rx2_open;  // level
        logic rx_frame;  // downlink delivered
        logic joined;    // join accept seen
        logic sleeping;  // level
        logic [7:0] port;// downlink port
    } lmci_radio_t;

    // remote command stream byte
    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } lmci_byte_t;

    // uplink request to the modem
    typedef struct packed {
        logic       start;
        logic       confirmed;
        logic [4:0] dbm;
        logic [3:0] sf;
        logic [7:0] port;
    } lmci_tx_t;

endpackage

// ==== hw/lmci_ind_out.sv ====
// one indication output with selectable polarity
`timescale 1ns/1ps
`default_nettype none
module lmci_ind_out (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_ce,
    input  wire logic i_cond,   // condition level
    input  wire logic i_pol,    // 0: active high, 1: inverted
    input  wire logic i_rst_v,  // reset level request; unused, the pin resets to 0
    output var  logic o_pin
);
    // registered so the pin never glitches on condition decode
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin <= 1'b0;
        end else if (i_ce) begin
            o_pin <= i_cond ^ i_pol;
        end
    end

    // reset value follows polarity on first enabled edge; a_ below
    a_pol_inverse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce |=> o_pin == ($past(i_cond) ^ $past(i_pol)))
        else $error("indication not condition xor polarity");
    // i_rst_v unused beyond documentation of intent would be a fault
    logic unused_rst_v;
    assign unused_rst_v = i_rst_v;
endmodule
`default_nettype wire

// ==== hw/lmci_top.sv ====
// command interpreter and indication outputs of the radio module
`timescale 1ns/1ps
`default_nettype none
module lmci_top
    import lmci_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_rst_n,
    input  wire logic               i_ce,
    input  wire logic [7:0]         i_addr,
    input  wire logic [31:0]        i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output var  logic [31:0]        o_rdata,
    input  wire logic               i_host_xfer,  // host data being handed
    input  wire lmci_pkg::lmci_radio_t i_radio,
    input  wire lmci_pkg::lmci_byte_t  i_rbyte,   // downlink payload bytes
    output var  lmci_pkg::lmci_tx_t    o_tx,
    output var  logic               o_join_req,
    output var  logic               o_sent_ok,
    output var  logic               o_sent_err,
    output var  logic               o_cmd_sep,    // remote command boundary
    output var  logic               o_resp_drop,
    output var  logic [NUM_IND-1:0] o_ind,
    output var  logic               o_cofreq
);
    import lmci_pkg::*;

    // --- pin synchronisers: host transfer level from outside domain
    logic xfer_s1_r;  // first stage, read only by second
    logic xfer_s2_r;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            xfer_s1_r <= 1'b0;
            xfer_s2_r <= 1'b0;
        end else if (i_ce) begin
            xfer_s1_r <= i_host_xfer;
            xfer_s2_r <= xfer_s1_r;
        end
    end

    // --- configuration registers
    logic [31:0] ctrl_r;      // co-frequency and polarity
    logic        type_r;      // default frame type
    logic [3:0]  count_r;     // default transmissions
    logic [2:0]  pwr_r;       // power index
    logic [4:0]  force_dbm_r; // forced power value
    logic        force_r;     // forced power enabled
    logic [2:0]  rate_r;      // default rate
    logic [7:0]  port_r;      // application port
    logic [3:0]  limit_r;     // unanswered confirmed sends before rejoin

    // clamp helper used for power and rate writes
    function automatic logic [2:0] clamp3(input logic [2:0] v,
                                          input logic [2:0] lim);
        clamp3 = (v > lim) ? lim : v;
    endfunction

    // software writes of settings
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_r      <= 32'h0000_0000;
            type_r      <= 1'b0;
            count_r     <= CNT_RST;
            pwr_r       <= 3'h0;
            force_dbm_r <= DBM_TOP;
            force_r     <= 1'b0;
            rate_r      <= 3'h0;
            port_r      <= PORT_RST;
            limit_r     <= MISS_LIMIT_RST;
        end else if (i_ce && i_wr) begin
            unique case (i_addr)
                ADDR_CTRL:    ctrl_r <= i_wdata;
                ADDR_CONFIRM: begin
                    type_r  <= i_wdata[CNF_TYPE];
                    count_r <= i_wdata[CNF_CNT_LO +: 4];
                end
                ADDR_POWER: begin
                    pwr_r   <= clamp3(i_wdata[2:0], PWR_IDX_MAX);
                    force_r <= i_wdata[PWR_FORCE];
                    // forced value capped at the documented ceiling
                    force_dbm_r <= (i_wdata[20:16] > DBM_FORCE)
                                 ? DBM_FORCE : i_wdata[20:16];
                end
                ADDR_RATE:    rate_r <= clamp3(i_wdata[2:0], RATE_MAX);
                ADDR_PORT:    port_r <= i_wdata[7:0];
                ADDR_LIMIT:   limit_r <= i_wdata[3:0];
                default: ;
            endcase
        end
    end
    assign o_cofreq = ctrl_r[CTRL_COFREQ];

    // --- channel table: three defaults, up to fifteen
    lmci_chan_t chan_r [NUM_CH];
    logic [3:0] ch_idx;
    assign ch_idx = i_wdata[CH_IDX_LO +: 4];
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_chan
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    chan_r[g] <= '{valid: (g < NUM_DEF_CH), freq: 16'h0000,
                                   min_dr: DEF_MIN_DR, max_dr: DEF_MAX_DR};
                end else if (i_ce && i_wr && i_addr == ADDR_CHAN
                             && ch_idx == 4'(g)) begin
                    chan_r[g].valid  <= 1'b1;
                    chan_r[g].freq   <= i_wdata[CH_FREQ_LO +: 16];
                    chan_r[g].min_dr <= i_wdata[CH_HASMIN]
                        ? i_wdata[CH_MIN_LO +: 3] : DEF_MIN_DR;
                    chan_r[g].max_dr <= i_wdata[CH_HASMAX]
                        ? i_wdata[CH_MAX_LO +: 3] : DEF_MAX_DR;
                end
            end
        end
    endgenerate
    // index 15 is outside the table and is ignored

    // channel mask for readback
    logic [NUM_CH-1:0] ch_mask;
    always_comb begin
        for (int k = 0; k < NUM_CH; k++) begin
            ch_mask[k] = chan_r[k].valid;
        end
    end

    // --- send sequencer
    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_RESULT} lmci_snd_t;
    lmci_snd_t snd_r;
    logic       cur_conf_r;   // frame type of this send
    logic [3:0] left_r;       // transmissions remaining
    logic       acked_r;      // ack seen this send
    logic       joined_r;     // network joined
    logic [3:0] miss_r;       // consecutive unanswered confirmed sends
    logic       send_wr;
    assign send_wr = i_ce && i_wr && i_addr == ADDR_SEND && snd_r == S_IDLE
                     && joined_r;

    // the sequencer; a send while busy or unjoined is refused
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            snd_r      <= S_IDLE;
            cur_conf_r <= 1'b0;
            left_r     <= 4'h0;
            acked_r    <= 1'b0;
        end else if (i_ce) begin
            unique case (snd_r)
                S_IDLE: if (send_wr) begin
                    // override only this transfer, defaults untouched
                    cur_conf_r <= i_wdata[SND_OVR] ? i_wdata[CNF_TYPE]
                                                   : type_r;
                    left_r     <= i_wdata[SND_OVR] ? i_wdata[CNF_CNT_LO +: 4]
                                                   : count_r;
                    acked_r    <= 1'b0;
                    snd_r      <= S_WAIT;
                end
                S_WAIT: if (i_radio.tx_done) begin
                    // unconfirmed frame, ack or count exhausted ends the send
                    if (!cur_conf_r || i_radio.ack || left_r <= 4'h1) begin
                        acked_r <= i_radio.ack;
                        snd_r   <= S_RESULT;
                    end
                    left_r <= left_r - 4'h1;
                end
                S_RESULT: snd_r <= S_IDLE;
                default: snd_r <= S_IDLE;
            endcase
        end
    end

    // uplink request: start pulses on entry and on each retry
    logic retry;
    assign retry = snd_r == S_WAIT && i_radio.tx_done && cur_conf_r
                   && !i_radio.ack && left_r > 4'h1;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx <= '0;
        end else if (i_ce) begin
            o_tx.start     <= send_wr || retry;
            o_tx.confirmed <= send_wr ? (i_wdata[SND_OVR] ? i_wdata[CNF_TYPE]
                                        : type_r) : o_tx.confirmed;
            // 2 dB per index below the top power
            o_tx.dbm  <= force_r ? force_dbm_r
                         : DBM_TOP - {1'b0, pwr_r, 1'b0};
            o_tx.sf   <= SF_TOP - {1'b0, rate_r};
            o_tx.port <= port_r;
        end
    end

    // result report, one pulse per send
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sent_ok  <= 1'b0;
            o_sent_err <= 1'b0;
        end else if (i_ce) begin
            o_sent_ok  <= snd_r == S_RESULT && (acked_r || !cur_conf_r);
            o_sent_err <= snd_r == S_RESULT && cur_conf_r && !acked_r;
        end
    end

    // link state: unanswered confirmed sends drop the link
    logic lost;
    assign lost = snd_r == S_RESULT && cur_conf_r && !acked_r
                  && miss_r + 4'h1 >= limit_r;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            joined_r   <= 1'b0;
            miss_r     <= 4'h0;
            o_join_req <= 1'b0;
        end else if (i_ce) begin
            o_join_req <= lost;
            if (lost) begin
                joined_r <= 1'b0;
                miss_r   <= 4'h0;
            end else if (i_radio.joined) begin
                joined_r <= 1'b1;
            end
            if (snd_r == S_RESULT && cur_conf_r && !lost) begin
                miss_r <= acked_r ? 4'h0 : miss_r + 4'h1;
            end
        end
    end

    // --- remote command stream on the reserved port
    logic       rem_act_r;   // downlink is remote command
    logic [7:0] resp_len_r;  // bytes of current response
    logic [7:0] cmd_cnt_r;   // commands split so far
    logic [7:0] drop_cnt_r;  // responses dropped
    logic       is_sep;
    assign is_sep = i_rbyte.valid && (i_rbyte.data == 8'h3B || i_rbyte.last);
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rem_act_r  <= 1'b0;
            resp_len_r <= 8'h00;
            cmd_cnt_r  <= 8'h00;
            drop_cnt_r <= 8'h00;
            o_cmd_sep  <= 1'b0;
            o_resp_drop <= 1'b0;
        end else if (i_ce) begin
            if (i_radio.rx_frame) begin
                rem_act_r <= i_radio.port == REMOTE_PORT;
            end
            // semicolon or payload end closes one command, in order
            o_cmd_sep   <= rem_act_r && is_sep;
            o_resp_drop <= rem_act_r && is_sep && resp_len_r >= RESP_MAX;
            if (rem_act_r && is_sep) begin
                cmd_cnt_r  <= cmd_cnt_r + 8'h01;
                resp_len_r <= 8'h00;
                if (resp_len_r >= RESP_MAX) begin
                    drop_cnt_r <= drop_cnt_r + 8'h01;
                end
            end else if (rem_act_r && i_rbyte.valid
                         && resp_len_r != 8'hFF) begin
                resp_len_r <= resp_len_r + 8'h01;
            end
        end
    end

    // --- indication conditions and pins
    logic [NUM_IND-1:0] cond;
    always_comb begin
        cond           = '0;
        cond[IND_BUSY] = xfer_s2_r || !joined_r;
        cond[IND_RX1]  = i_radio.rx1_open;
        cond[IND_RX2]  = i_radio.rx2_open;
        cond[IND_SLP]  = i_radio.sleeping;
        cond[IND_TX]   = snd_r == S_WAIT;
        cond[IND_RXA]  = i_radio.rx_frame;
    end
    generate
        for (g = 0; g < NUM_IND; g++) begin : g_ind
            lmci_ind_out u_ind (
                .i_clk   (i_clk),
                .i_rst_n (i_rst_n),
                .i_ce    (i_ce),
                .i_cond  (cond[g]),
                .i_pol   (ctrl_r[CTRL_POL_LO + g]),
                .i_rst_v (1'b1),
                .o_pin   (o_ind[g])
            );
        end
    endgenerate

    // --- register read, data one cycle later
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_ce) begin
            o_rdata <= 32'h0000_0000;
            if (i_rd) begin
                unique case (i_addr)
                    ADDR_CTRL:    o_rdata <= ctrl_r;
                    ADDR_CONFIRM: o_rdata <= {24'h0, count_r, 3'h0, type_r};
                    ADDR_POWER:   o_rdata <= {11'h0, force_dbm_r, 7'h0,
                                              force_r, 5'h0, pwr_r};
                    ADDR_RATE:    o_rdata <= {29'h0, rate_r};
                    ADDR_PORT:    o_rdata <= {24'h0, port_r};
                    ADDR_STATUS:  o_rdata <= {24'h0, miss_r, 1'b0, joined_r,
                                              snd_r};
                    ADDR_CHMASK:  o_rdata <= {17'h0, ch_mask};
                    ADDR_LIMIT:   o_rdata <= {28'h0, limit_r};
                    ADDR_REMOTE:  o_rdata <= {16'h0, drop_cnt_r, cmd_cnt_r};
                    default:      o_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // --- assertions
    a_busy_unjoined: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && !joined_r
        |=> o_ind[IND_BUSY] != $past(ctrl_r[CTRL_POL_LO]))
        else $error("busy not asserted while unjoined");
    a_report_once: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(o_sent_ok && o_sent_err))
        else $error("both send results at once");
    a_result_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && snd_r == S_RESULT |=> o_sent_ok || o_sent_err)
        else $error("send ended without result");
    a_retry_bound: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        retry |-> left_r > 4'h1 && !i_radio.ack)
        else $error("retry after ack or count spent");
    a_rejoin_req: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && lost |=> o_join_req && !joined_r)
        else $error("lost link without join request");
    a_rate_map: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce |=> o_tx.sf == SF_TOP - {1'b0, $past(rate_r)})
        else $error("rate index not mapped to spreading factor");
    a_remote_port: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_radio.rx_frame && i_radio.port != REMOTE_PORT
        |=> !rem_act_r)
        else $error("user port treated as remote command");
    a_cofreq_out: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_wr && i_addr == ADDR_CTRL
        |=> o_cofreq == $past(i_wdata[CTRL_COFREQ]))
        else $error("co-frequency output wrong");
    c_send_ok: cover property (@(posedge i_clk) o_sent_ok);
    c_send_err: cover property (@(posedge i_clk) o_sent_err);
    c_rejoin: cover property (@(posedge i_clk) o_join_req);
    c_drop: cover property (@(posedge i_clk) o_resp_drop);
endmodule
`default_nettype wire

// ==== dv/lmci_modem_model.sv ====
// behavioural modem: answers each uplink start with done and optional ack
`timescale 1ns/1ps
`default_nettype none
module lmci_modem_model (
    input  wire logic i_clk,
    input  wire logic i_start,
    input  wire logic i_ack_en, // bench decides whether the server answers
    output logic      o_tx_done,
    output logic      o_ack
);
    initial {o_tx_done, o_ack} = 2'b00;
    // air time drawn per uplink, so answers come prompt or slow
    always @(posedge i_clk) begin
        o_tx_done <= 1'b0;
        o_ack     <= 1'b0;
        if (i_start) begin
            repeat (1 + $urandom % 4) @(posedge i_clk);
            o_tx_done <= 1'b1;
            o_ack     <= i_ack_en;
        end
    end
endmodule
`default_nettype wire

// ==== dv/lmci_top_tb.sv ====
// randomised self-checking bench for the command and indication block
`timescale 1ns/1ps
`default_nettype none
module lmci_top_tb;
    import lmci_pkg::*;
    logic        clk = 0, rst_n = 0, wr = 0, rd = 0, xfer = 0, ack_en = 0;
    logic        ce = 1;
    logic [7:0]  addr = '0;
    logic [31:0] wdata = '0, rdata;
    lmci_radio_t radio = '0, rad;
    lmci_byte_t  rbyte = '0;
    lmci_tx_t    tx, tx_seen;
    logic        done, ackm, join_req, ok, err, sep, drop, cofreq;
    logic [5:0]  ind;
    int bad_count = 0, n_checks = 0, n_ok = 0, n_err = 0, n_st = 0;
    int n_sep = 0, n_join = 0, n_drop = 0;
    always #2.5 clk = ~clk;
    // modem events merged into the radio struct
    always_comb begin
        rad = radio;
        rad.tx_done = done;
        rad.ack = ackm;
    end
    lmci_top i_lmci_top (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_host_xfer(xfer), .i_radio(rad), .i_rbyte(rbyte), .o_tx(tx),
        .o_join_req(join_req), .o_sent_ok(ok), .o_sent_err(err),
        .o_cmd_sep(sep), .o_resp_drop(drop), .o_ind(ind), .o_cofreq(cofreq));
    lmci_modem_model i_lmci_modem_model (.i_clk(clk), .i_start(tx.start),
        .i_ack_en(ack_en), .o_tx_done(done), .o_ack(ackm));
    // pulse counters; old values are read at the edge, so no race
    always @(posedge clk) begin
        if (tx.start === 1'b1) begin
            n_st++;
            tx_seen = tx;
        end
        n_ok += ok; n_err += err; n_sep += sep;
        n_join += join_req; n_drop += drop;
    end
    task automatic chk(input logic [31:0] seen, exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk); addr <= a; wdata <= d; wr <= 1;
        @(posedge clk); wr <= 0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk); addr <= a; rd <= 1;
        @(posedge clk); rd <= 0;
        @(negedge clk); chk(rdata, e, "rdata");
    endtask
    // send with override bit; waits on the result pulse, bounded
    task automatic send(input logic ov, cf, input logic [3:0] cnt, input logic a);
        int b;
        b = n_ok + n_err;
        ack_en <= a;
        wr_reg(ADDR_SEND, {23'h0, ov, cnt, 3'b000, cf});
        for (int i = 0; i < 300 && n_ok + n_err == b; i++) @(negedge clk);
    endtask
    // downlink: ';' at byte 1, last flag on the final byte
    task automatic remote(input logic [7:0] p, input int len);
        @(posedge clk); radio.rx_frame <= 1; radio.port <= p;
        @(posedge clk); radio.rx_frame <= 0;
        for (int i = 0; i < len; i++) begin
            rbyte <= {1'b1, i == len - 1, (i == 1) ? 8'h3B : 8'h61};
            @(posedge clk);
        end
        rbyte <= '0;
        repeat (4) @(posedge clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // watchdog well beyond the expected few hundred cycles
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        int p, r, q, s;
        void'($urandom(17));
        repeat (6) @(posedge clk);
        rst_n <= 1;
        @(posedge clk); @(negedge clk);
        chk(ind[IND_BUSY], 1, "busy at start");
        rd_chk(ADDR_CHMASK, 32'h0000_0007);
        rd_chk(ADDR_LIMIT, 32'h0000_0004);
        rd_chk(8'hFC, 32'h0000_0000);
        // channel 5 added with rates omitted; index 15 lies outside
        wr_reg(ADDR_CHAN, 32'h1234_0005);
        wr_reg(ADDR_CHAN, 32'h0000_000F);
        rd_chk(ADDR_CHMASK, 32'h0000_0027);
        wr_reg(ADDR_CTRL, 32'h0000_3F01);
        repeat (3) @(negedge clk);
        chk(cofreq, 1, "cofreq");
        chk(ind, 6'h3E, "inverted");
        wr_reg(ADDR_CTRL, 32'h0000_0000);
        @(posedge clk) radio.joined <= 1;
        @(posedge clk) radio.joined <= 0;
        repeat (4) @(negedge clk);
        chk(ind[IND_BUSY], 0, "busy joined");
        // clock enable low freezes the busy line despite the transfer
        @(posedge clk) ce <= 0;
        xfer <= 1;
        repeat (6) @(negedge clk);
        chk(ind[IND_BUSY], 0, "frozen");
        @(posedge clk) ce <= 1;
        repeat (6) @(negedge clk);
        chk(ind[IND_BUSY], 1, "busy xfer");
        xfer <= 0;
        repeat (6) @(negedge clk);
        chk(ind[IND_BUSY], 0, "busy done");
        repeat (8) begin
            @(posedge clk);
            {radio.rx1_open, radio.rx2_open, radio.sleeping} <= 3'($urandom);
            repeat (4) @(negedge clk);
            chk(ind[3:1], {radio.sleeping, radio.rx2_open, radio.rx1_open},
                "levels");
        end
        {radio.rx1_open, radio.rx2_open, radio.sleeping} <= 3'b000;
        for (p = 0; p < 8; p++) begin
            r = $urandom % 6;
            q = 1 + $urandom % 220;
            wr_reg(ADDR_POWER, p); wr_reg(ADDR_RATE, r); wr_reg(ADDR_PORT, q);
            send(1, 0, 1, 0);
            chk(tx_seen.dbm, 20 - 2 * p, "dbm");
            chk(tx_seen.sf, 12 - r, "sf");
            chk(tx_seen.port, q, "port");
        end
        chk(n_ok, 8, "ok count");
        wr_reg(ADDR_POWER, 32'h0016_0100);
        send(1, 0, 1, 0);
        chk(tx_seen.dbm, 22, "forced dbm");
        s = n_st;
        send(1, 1, 3, 0);
        chk(n_st - s, 3, "retries");
        chk(n_err, 1, "err count");
        s = n_st;
        send(1, 1, 3, 1);
        chk(n_st - s, 1, "acked once");
        wr_reg(ADDR_CONFIRM, 32'h0000_0011);
        send(1, 0, 1, 1);
        chk(tx_seen.confirmed, 0, "override");
        send(0, 0, 0, 1);
        chk(tx_seen.confirmed, 1, "default back");
        remote(8'd221, 3);
        remote(8'd5, 3);
        remote(8'd221, 70);
        chk(n_sep, 4, "separators");
        chk(n_drop, 1, "dropped");
        wr_reg(ADDR_LIMIT, 32'h0000_0001);
        send(1, 1, 1, 0);
        repeat (4) @(negedge clk);
        chk(n_join, 1, "rejoin");
        chk(ind[IND_BUSY], 1, "busy unjoined");
        tally_and_finish();
    end
endmodule
`default_nettype wire
